/* host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // Hang flag
  output logic timedOut
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, timedOut} = '0;
  end
  // Address and data offered together
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) timedOut <= 1'b1;
  endtask : write
  // Every read carries its address again
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) timedOut <= 1'b1;
  endtask : read
endmodule : host_model
`default_nettype wire

/* scan_command_and_readout.sv */
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module scan_command_and_readout
  import scan_pkg::*;
#(
  parameter int BUF_DEPTH = 1024,
  parameter int HOLD_COUNT = HOLD_CYCLES,
  parameter int TBL_AW = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pixel source from the sensor path
  input wire pixel_t pixelIn,
  input wire logic pixelValid,
  output logic pixelReady,
  // Table memory port
  output logic [TBL_AW-1:0] tableAddr,
  output logic tableRead,
  input wire logic [7:0] tableData,
  // Paper sensors and pins
  input wire logic [1:0] paperSensorPin,
  input wire logic host_interface_select_pin,
  // Motor, clock, pass-through and mode outputs
  output logic motorStep,
  output logic motorReverse,
  output logic motorEnable,
  output logic motorOutputEnable,
  output logic clockRun,
  output logic passThrough,
  output logic [1:0] acquireMode
);
  localparam int PW = $clog2(BUF_DEPTH);

  typedef enum {ST_IDLE, ST_SKIP, ST_ACQ, ST_FEED, ST_AFTER, ST_HALT} state_t;
  state_t state;

  // Configuration
  logic [7:0] target, portLo, portHi, motorCfg, format, sense;
  logic [1:0] command;
  logic standby, resetBit;
  logic [7:0] skipCnt, afterCnt;
  logic coefPhase;
  logic [7:0] prefetch;
  // Sensor synchroniser, three stages
  logic [1:0] sensA, sensB, sensC, sensPrev;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sensA <= 2'h0;
      sensB <= 2'h0;
      sensC <= 2'h0;
      sensPrev <= 2'h0;
    end else begin
      sensA <= paperSensorPin;
      sensB <= sensA;
      sensC <= sensB;
      if (sensB == sensC) begin
        sensPrev <= sensC;
      end
    end
  end
  wire [1:0] sensStable = (sensB == sensC) ? sensC : sensPrev;
  wire [1:0] sensChange = (sensStable ^ sensPrev) & sense[1:0];
  wire [1:0] sensTrue = sensStable & sense[1:0];

  // Line buffer
  logic [7:0] lineBuf [BUF_DEPTH];
  logic [PW:0] wrPtr, rdPtr;
  wire [PW:0] fill = wrPtr - rdPtr;
  wire bufFull = fill >= (PW+1)'(BUF_DEPTH - 2);
  wire bufEmpty = fill == '0;

  // Bus handshakes
  logic awHeld, wHeld;
  logic [7:0] awA;
  logic [31:0] wD;
  logic [3:0] wS;
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  wire awGo = awHeld || (awvalid && awready);
  wire wGo = wHeld || (wvalid && wready);
  wire [7:0] wAddr = awHeld ? awA : awaddr;
  wire [7:0] wByte = wHeld ? wD[7:0] : wdata[7:0];
  wire wLane = wHeld ? wS[0] : wstrb[0];
  wire doWrite = awGo && wGo && !bvalid;
  wire wrOn = doWrite && wLane;
  assign arready = !rvalid;
  wire doRead = arvalid && arready;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_PIXEL) || (a == ADDR_STATUS) || (a == ADDR_TARGET) ||
             (a == ADDR_PORT_LO) || (a == ADDR_PORT_HI) || (a == ADDR_DATAPORT) ||
             (a == ADDR_COMMAND) || (a == ADDR_MOTOR) || (a == ADDR_FORMAT) ||
             (a == ADDR_SENSE);
  endfunction : mapped

  wire cmdWrite = wrOn && wAddr == ADDR_COMMAND;
  wire [1:0] newCmd = wByte[1:0];
  wire gammaSel = target[BIT_GAMMA];
  wire [15:0] portAddr = {portHi, portLo};
  wire pixRead = doRead && araddr == ADDR_PIXEL;
  wire portRead = doRead && araddr == ADDR_DATAPORT;
  wire portAddrWrite = wrOn && wAddr == ADDR_DATAPORT;
  wire popByte = pixRead && !bufEmpty;
  wire twelve = format[2];
  wire [1:0] depth = twelve ? DEPTH_8 : format[1:0];
  // Address step: every gamma read, every second coefficient read
  wire portStep = portRead && (gammaSel || coefPhase);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awA <= 8'h00;
      wD <= 32'h0;
      wS <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready && !(wGo)) begin
        awHeld <= 1'b1;
        awA <= awaddr;
      end
      if (wvalid && wready && !(awGo)) begin
        wHeld <= 1'b1;
        wD <= wdata;
        wS <= wstrb;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Configuration writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      target <= 8'h00;
      portLo <= 8'h00;
      portHi <= 8'h00;
      motorCfg <= 8'h00;
      format <= 8'h00;
      sense <= 8'h00;
      command <= CMD_IDLE;
      standby <= 1'b1;
      resetBit <= 1'b1;
      coefPhase <= 1'b0;
    end else begin
      if (wrOn && wAddr == ADDR_TARGET) target <= wByte;
      if (wrOn && wAddr == ADDR_MOTOR) motorCfg <= wByte;
      if (wrOn && wAddr == ADDR_FORMAT) format <= wByte;
      if (wrOn && wAddr == ADDR_SENSE) sense <= wByte;
      if (wrOn && wAddr == ADDR_PORT_HI) portHi <= wByte;
      if (wrOn && wAddr == ADDR_PORT_LO) begin
        portLo <= wByte;
        coefPhase <= 1'b0;
      end else if (portStep) begin
        {portHi, portLo} <= portAddr + 16'h0001;
        coefPhase <= 1'b0;
      end else if (portRead) begin
        coefPhase <= 1'b1;
      end
      if (cmdWrite) begin
        command <= newCmd;
        standby <= wByte[BIT_STANDBY];
        resetBit <= wByte[BIT_RESET];
      end else if (state == ST_IDLE && command != CMD_SCAN && command != CMD_IDLE) begin
        command <= CMD_IDLE;
      end
    end
  end
  // Table prefetch; gamma fetched from current address each read
  assign tableAddr = portAddr[TBL_AW-1:0];
  assign tableRead = portAddrWrite || portRead || (wrOn && wAddr == ADDR_PORT_LO);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prefetch <= 8'h00;
    else if (tableRead) prefetch <= tableData;
  end

  // Scan and feed sequencer
  logic [$clog2(HOLD_COUNT+1)-1:0] holdCnt;
  logic pauseLatched;
  wire scanSet = cmdWrite && newCmd == CMD_SCAN && command != CMD_SCAN;
  wire machineReset = resetBit || standby;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      skipCnt <= 8'h00;
      afterCnt <= 8'h00;
      holdCnt <= '0;
    end else if (machineReset) begin
      state <= ST_IDLE;
      holdCnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (scanSet) begin
            state <= ST_SKIP;
            skipCnt <= motorCfg;
          end else if (cmdWrite && (newCmd == CMD_FWD || newCmd == CMD_REV)) begin
            state <= ST_FEED;
          end
        end
        ST_SKIP: begin
          if (cmdWrite && newCmd != CMD_SCAN) state <= ST_IDLE;
          else if (skipCnt == 8'h00) state <= ST_ACQ;
          else skipCnt <= skipCnt - 8'h01;
        end
        ST_ACQ: begin
          if ((cmdWrite && newCmd != CMD_SCAN) || sensChange != 2'h0) begin
            state <= ST_IDLE;
          end else if (bufFull) begin
            state <= ST_HALT;
            holdCnt <= '0;
          end
        end
        ST_HALT: begin
          if (cmdWrite && newCmd != CMD_SCAN) state <= ST_IDLE;
          else if (!bufFull) state <= ST_ACQ;
          else if (holdCnt != $bits(holdCnt)'(HOLD_COUNT)) holdCnt <= holdCnt + 1'b1;
        end
        ST_FEED: begin
          if (cmdWrite && newCmd != command) state <= ST_IDLE;
          else if (sensTrue[0]) state <= ST_IDLE;
          else if (sensTrue[1]) begin
            if (command == CMD_FWD && motorCfg != 8'h00) begin
              state <= ST_AFTER;
              afterCnt <= motorCfg;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_AFTER: begin
          if (cmdWrite || afterCnt == 8'h01) state <= ST_IDLE;
          else afterCnt <= afterCnt - 8'h01;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Line buffer fill: sensor order, packing, 12-bit split
  fmt_t fmt;
  logic [7:0] packReg;
  logic [3:0] packCnt;
  logic [3:0] lowHold;
  logic [7:0] lowByte;
  logic statusPending;
  logic [7:0] statusByte;
  wire acquiring = state == ST_ACQ;
  wire [3:0] perByte = (depth == DEPTH_4) ? 4'h2 : (depth == DEPTH_2) ? 4'h4 :
                       (depth == DEPTH_1) ? 4'h8 : 4'h1;
  wire [7:0] bits8 = pixelIn.value[11:4];
  wire [7:0] packNext = (depth == DEPTH_4) ? {packReg[3:0], bits8[7:4]} :
                        (depth == DEPTH_2) ? {packReg[5:0], bits8[7:6]} :
                        (depth == DEPTH_1) ? {packReg[6:0], bits8[7]} : bits8;
  wire canPush = !bufFull && acquiring && fmt == FMT_WORD && !statusPending;
  assign pixelReady = canPush;
  wire take = pixelValid && canPush;
  wire packDone = packCnt + 4'h1 == perByte;
  wire pushByte = (take && !twelve && packDone) || (take && twelve) ||
                  (fmt == FMT_LOW && !bufFull) || (statusPending && !bufFull);
  wire [7:0] pushData = statusPending && fmt == FMT_WORD ? statusByte :
                        fmt == FMT_LOW ? lowByte :
                        twelve ? {4'h0, pixelIn.value[11:8]} : packNext;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt <= FMT_WORD;
      packReg <= 8'h00;
      packCnt <= 4'h0;
      lowByte <= 8'h00;
      statusPending <= 1'b0;
      statusByte <= 8'h00;
      wrPtr <= '0;
      pauseLatched <= 1'b0;
    end else if (machineReset || scanSet) begin
      fmt <= FMT_WORD;
      packCnt <= 4'h0;
      statusPending <= 1'b0;
      wrPtr <= rdPtr;
      pauseLatched <= 1'b0;
    end else begin
      if (state == ST_HALT) pauseLatched <= 1'b1;
      if (pushByte) begin
        lineBuf[wrPtr[PW-1:0]] <= pushData;
        wrPtr <= wrPtr + 1'b1;
      end
      if (take) begin
        packReg <= packNext;
        packCnt <= (twelve || packDone) ? 4'h0 : packCnt + 4'h1;
        if (twelve) begin
          fmt <= FMT_LOW;
          lowByte <= pixelIn.value[7:0];
        end
        if (pixelIn.lineEnd) begin
          statusPending <= 1'b1;
          statusByte <= 8'(pixelIn.pauseStart || pauseLatched) << STATUS_PAUSE;
        end
      end else if (fmt == FMT_LOW && !bufFull) begin
        fmt <= FMT_WORD;
      end else if (statusPending && !bufFull) begin
        statusPending <= 1'b0;
        pauseLatched <= 1'b0;
      end
    end
  end

  // Read channel
  wire [7:0] rdSel = (araddr == ADDR_PIXEL) ? (bufEmpty ? 8'h00 : lineBuf[rdPtr[PW-1:0]]) :
                     (araddr == ADDR_STATUS) ? {6'h0, state == ST_HALT, !bufEmpty} :
                     (araddr == ADDR_TARGET) ? target :
                     (araddr == ADDR_PORT_LO) ? portLo :
                     (araddr == ADDR_PORT_HI) ? portHi :
                     (araddr == ADDR_DATAPORT) ? (gammaSel ? tableData : prefetch) :
                     (araddr == ADDR_COMMAND) ? {4'h0, resetBit, standby, command} :
                     (araddr == ADDR_MOTOR) ? motorCfg :
                     (araddr == ADDR_FORMAT) ? format :
                     (araddr == ADDR_SENSE) ? {4'h0, sensStable, sense[1:0]} : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
      rdPtr <= '0;
    end else begin
      if (doRead) begin
        rvalid <= 1'b1;
        rdata <= {24'h0, rdSel};
        rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      if (popByte) rdPtr <= rdPtr + 1'b1;
    end
  end
  // Motor and mode outputs
  logic stepToggle;
  wire moving = state == ST_SKIP || state == ST_ACQ || state == ST_FEED || state == ST_AFTER;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) stepToggle <= 1'b0;
    else stepToggle <= moving ? !stepToggle : 1'b0;
  end
  assign motorStep = stepToggle;
  assign motorReverse = state == ST_FEED && command == CMD_REV;
  assign motorEnable = moving ||
                       (state == ST_HALT && holdCnt != $bits(holdCnt)'(HOLD_COUNT));
  assign motorOutputEnable = !standby;
  assign clockRun = !standby;
  assign passThrough = resetBit && !host_interface_select_pin;
  assign acquireMode = {acquiring, twelve};
endmodule : scan_command_and_readout
`default_nettype wire

/* scan_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module scan_monitor
  import scan_pkg::*;
#(
  parameter int HOLD_COUNT = HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Pins
  input wire logic host_interface_select_pin,
  input wire logic passThrough,
  input wire logic clockRun,
  input wire logic motorOutputEnable,
  input wire logic motorStep,
  input wire logic motorEnable
);
  logic prevStep;
  int stillCount;
  // Cycles with power on but no step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevStep <= 1'b0;
      stillCount <= 0;
    end else begin
      prevStep <= motorStep;
      stillCount <= (motorEnable && motorStep == prevStep) ? stillCount + 1 : 0;
    end
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("write response missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read response missing");
  a_read_blocked: assert property (rvalid |-> !arready)
    else $error("read taken while answer pending");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_standby_float: assert property (!clockRun |-> !motorOutputEnable)
    else $error("motor driven in standby");
  a_standby_frozen: assert property (!clockRun && $past(!clockRun) |-> $stable(motorStep))
    else $error("motor stepped in standby");
  a_select_high: assert property (host_interface_select_pin |-> !passThrough)
    else $error("pass-through with select high");
  a_reset_pass: assert property ($fell(rst) |-> passThrough == !host_interface_select_pin)
    else $error("pass-through wrong after reset");
  a_hold_timeout: assert property (stillCount <= HOLD_COUNT + 4)
    else $error("motor power kept past hold timeout");
endmodule : scan_monitor
bind scan_command_and_readout scan_monitor #(.HOLD_COUNT(HOLD_COUNT)) mon_u (
  .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .host_interface_select_pin(host_interface_select_pin), .passThrough(passThrough),
  .clockRun(clockRun), .motorOutputEnable(motorOutputEnable), .motorStep(motorStep),
  .motorEnable(motorEnable)
);
`default_nettype wire

/* scan_pkg.sv */
package scan_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_PIXEL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TARGET = 8'h0C;
  localparam logic [7:0] ADDR_PORT_LO = 8'h10;
  localparam logic [7:0] ADDR_PORT_HI = 8'h14;
  localparam logic [7:0] ADDR_DATAPORT = 8'h18;
  localparam logic [7:0] ADDR_COMMAND = 8'h1C;
  localparam logic [7:0] ADDR_MOTOR = 8'h20;
  localparam logic [7:0] ADDR_FORMAT = 8'h24;
  localparam logic [7:0] ADDR_SENSE = 8'h28;
  // Command field values and bits
  localparam logic [1:0] CMD_IDLE = 2'h0;
  localparam logic [1:0] CMD_FWD = 2'h1;
  localparam logic [1:0] CMD_REV = 2'h2;
  localparam logic [1:0] CMD_SCAN = 2'h3;
  localparam int BIT_STANDBY = 2;
  localparam int BIT_RESET = 3;
  // Target register bit: gamma when set, coefficients when clear
  localparam int BIT_GAMMA = 0;
  // Pixel depth codes
  localparam logic [1:0] DEPTH_8 = 2'h0;
  localparam logic [1:0] DEPTH_4 = 2'h1;
  localparam logic [1:0] DEPTH_2 = 2'h2;
  localparam logic [1:0] DEPTH_1 = 2'h3;
  localparam int STATUS_PAUSE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Hold current timeout
  localparam int HOLD_TIMEOUT_US = 1000;
  localparam int CLK_MHZ = 20;
  localparam int HOLD_CYCLES = HOLD_TIMEOUT_US * CLK_MHZ;
  typedef struct packed {
    logic [11:0] value;
    logic lineEnd;
    logic pauseStart;
  } pixel_t;
  typedef enum logic [1:0] {FMT_WORD, FMT_HIGH, FMT_LOW} fmt_t;
endpackage : scan_pkg

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import scan_pkg::*;
;
  logic clk, rst, pixelValid, pixelReady, tableRead, selPin, timedOut, s;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic motorStep, motorReverse, motorEnable, motorOutputEnable, clockRun, passThrough;
  logic [7:0] awaddr, araddr, tableData;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, paperSensorPin, acquireMode;
  logic [9:0] tableAddr;
  pixel_t pixelIn;
  int miscompares, testsRun, k;
  assign tableData = tableAddr[7:0] ^ 8'hA5;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  host_model host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .timedOut(timedOut));
  scan_command_and_readout #(.BUF_DEPTH(16), .HOLD_COUNT(20), .TBL_AW(10)) dut_u (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pixelIn(pixelIn),
    .pixelValid(pixelValid), .pixelReady(pixelReady), .tableAddr(tableAddr),
    .tableRead(tableRead), .tableData(tableData), .paperSensorPin(paperSensorPin),
    .host_interface_select_pin(selPin), .motorStep(motorStep), .motorReverse(motorReverse),
    .motorEnable(motorEnable), .motorOutputEnable(motorOutputEnable), .clockRun(clockRun),
    .passThrough(passThrough), .acquireMode(acquireMode));
  task automatic print_verdict();
    if (miscompares == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic hang();
    miscompares++;
    print_verdict();
  endtask : hang
  always @(posedge clk) if (timedOut === 1'b1) hang();
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.write(a, d);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    host_u.read(a, v, rr);
    chk(nm, e, v & m);
  endtask : rchk
  task automatic push(input logic [11:0] pv, input logic e, input logic p);
    int n;
    @(posedge clk);
    pixelIn <= '{value: pv, lineEnd: e, pauseStart: p};
    pixelValid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!pixelReady && n < 100);
    pixelValid <= 1'b0;
    if (n >= 100) hang();
  endtask : push
  initial begin
    rst = 1'b1;
    pixelIn = '0;
    pixelValid = 1'b0;
    paperSensorPin = 2'h0;
    selPin = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("passThrough", 32'h1, 32'(passThrough));
    rchk("command", ADDR_COMMAND, 32'hFF, 32'h0C);
    chk("clockRun", 32'h0, 32'(clockRun));
    wr(ADDR_COMMAND, 32'h0);
    #1 chk("passOff", 32'h0, 32'(passThrough));
    wr(ADDR_TARGET, 32'h1);
    wr(ADDR_PORT_LO, 32'h2);
    wr(ADDR_PORT_HI, 32'h0);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr(ADDR_DATAPORT, 32'h0);
      rchk("gamma", ADDR_DATAPORT, 32'hFF, 32'(8'(i + 2) ^ 8'hA5));
    end
    wr(ADDR_TARGET, 32'h0);
    wr(ADDR_PORT_LO, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DATAPORT, 32'h0);
      rchk("coef", ADDR_DATAPORT, 32'hFF, 32'(8'(i / 2) ^ 8'hA5));
    end
    wr(ADDR_FORMAT, 32'h4);
    wr(ADDR_MOTOR, 32'h0);
    wr(ADDR_SENSE, 32'h0);
    wr(ADDR_COMMAND, 32'(CMD_SCAN));
    push(12'hABC, 1'b0, 1'b0);
    chk("mode", 32'h3, 32'(acquireMode));
    push(12'h123, 1'b1, 1'b1);
    rchk("pixHi", ADDR_PIXEL, 32'hFFFFFFFF, 32'h0A);
    rchk("pixLo", ADDR_PIXEL, 32'hFFFFFFFF, 32'hBC);
    rchk("dataFlag", ADDR_STATUS, 32'h1, 32'h1);
    rchk("pixHi2", ADDR_PIXEL, 32'hFF, 32'h01);
    rchk("pixLo2", ADDR_PIXEL, 32'hFF, 32'h23);
    rchk("pause", ADDR_PIXEL, 32'h2, 32'h2);
    rchk("empty", ADDR_PIXEL, 32'hFFFFFFFF, 32'h0);
    @(posedge clk);
    pixelIn <= '{value: 12'h5A5, lineEnd: 1'b0, pauseStart: 1'b0};
    pixelValid <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (pixelReady) k++;
    end
    pixelValid <= 1'b0;
    chk("accepted", 32'h7, 32'(k));
    rchk("halted", ADDR_STATUS, 32'h2, 32'h2);
    repeat (40) @(posedge clk);
    #1 chk("motorOff", 32'h0, 32'(motorEnable));
    wr(ADDR_COMMAND, 32'(CMD_IDLE));
    #1 chk("stopped", 32'h0, 32'(acquireMode[1]));
    rchk("notHalted", ADDR_STATUS, 32'h2, 32'h0);
    rchk("kept", ADDR_PIXEL, 32'hFF, 32'h05);
    wr(ADDR_COMMAND, 32'(CMD_SCAN));
    rchk("cleared", ADDR_PIXEL, 32'hFF, 32'h0);
    wr(ADDR_FORMAT, 32'(DEPTH_4));
    push(12'hA00, 1'b0, 1'b0);
    push(12'h3FF, 1'b1, 1'b0);
    rchk("pack4", ADDR_PIXEL, 32'hFF, 32'hA3);
    rchk("status4", ADDR_PIXEL, 32'hFF, 32'h00);
    wr(ADDR_COMMAND, 32'(CMD_IDLE));
    wr(ADDR_SENSE, 32'h1);
    for (int c = 1; c < 3; c++) begin
      wr(ADDR_COMMAND, 32'(c));
      repeat (4) @(posedge clk);
      #1 s = motorStep;
      chk("direction", 32'(c - 1), 32'(motorReverse));
      @(posedge clk);
      #1 chk("stepping", 32'(!s), 32'(motorStep));
      @(posedge clk);
      paperSensorPin <= 2'h1;
      repeat (10) @(posedge clk);
      #1 s = motorStep;
      @(posedge clk);
      #1 chk("sensorStop", 32'(s), 32'(motorStep));
      @(posedge clk);
      paperSensorPin <= 2'h0;
      wr(ADDR_COMMAND, 32'(CMD_IDLE));
    end
    wr(ADDR_SENSE, 32'h2);
    wr(ADDR_MOTOR, 32'h10);
    for (int c = 1; c < 3; c++) begin
      wr(ADDR_COMMAND, 32'(c));
      @(posedge clk);
      paperSensorPin <= 2'h2;
      repeat (10) @(posedge clk);
      #1 s = motorStep;
      @(posedge clk);
      #1 chk("afterSensor2", 32'(c == 1 ? !s : s), 32'(motorStep));
      repeat (30) @(posedge clk);
      #1 s = motorStep;
      @(posedge clk);
      #1 chk("afterStop", 32'(s), 32'(motorStep));
      @(posedge clk);
      paperSensorPin <= 2'h0;
      wr(ADDR_COMMAND, 32'(CMD_IDLE));
    end
    wr(ADDR_COMMAND, 32'h4);
    #1 chk("clockStop", 32'h0, 32'(clockRun));
    chk("motorFloat", 32'h0, 32'(motorOutputEnable));
    host_u.read(8'h04, v, rr);
    chk("unmapped", 32'(RESP_SLVERR), 32'(rr));
    wr(ADDR_COMMAND, 32'h8);
    #1 chk("resetPass", 32'h1, 32'(passThrough));
    rchk("keptCfg", ADDR_MOTOR, 32'hFF, 32'h10);
    @(posedge clk);
    selPin <= 1'b1;
    @(posedge clk);
    #1 chk("selHigh", 32'h0, 32'(passThrough));
    print_verdict();
  end
endmodule : tb
`default_nettype wire
